//--- rtl/sbi_pkg.sv
// package of constants for the servo brake, index and configuration block
`default_nettype none
package sbi_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] SBI_CTRL_OFF = 8'h00;
    localparam logic [7:0] SBI_STAT_OFF = 8'h04;
    localparam logic [7:0] SBI_PAR_OFF = 8'h20;
    localparam logic [7:0] SBI_PPCMD_OFF = 8'h0C;
    localparam logic [7:0] SBI_TRQ_OFF = 8'h10;
    localparam logic [7:0] SBI_SAVE_OFF = 8'h14;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SBI_CTRL_ENA = 0;
    localparam int SBI_CTRL_MODE_LO = 1;
    localparam int SBI_STAT_BRK = 0;
    localparam int SBI_STAT_INPOS = 1;
    localparam int SBI_STAT_BUSY = 2;
    localparam int SBI_STAT_BAD = 3;
    localparam int SBI_STAT_PPREJ = 4;
    localparam int SBI_STAT_SAVES_LO = 8;
    // ----------------------------------------------------------------
    // parameter table: word index in the low bits of the par address
    // ----------------------------------------------------------------
    localparam int SBI_NPAR = 8;
    localparam logic [2:0] SBI_P_MAIN = 3'h0;
    localparam logic [2:0] SBI_P_VEL = 3'h1;
    localparam logic [2:0] SBI_P_INT = 3'h2;
    localparam logic [2:0] SBI_P_TRQ = 3'h3;
    localparam logic [2:0] SBI_P_WIN = 3'h4;
    localparam logic [6:0] SBI_PAR_MIN = 7'h01;
    localparam logic [6:0] SBI_PAR_MAX = 7'h7F;
    localparam logic [6:0] SBI_BRAKE_SEL = 7'h7F;
    localparam logic [6:0] SBI_TRQ_RST = 7'h7F;
    localparam logic [6:0] SBI_WIN_RST = 7'h0A;
    localparam logic [6:0] SBI_GAIN_RST = 7'h20;
    // ----------------------------------------------------------------
    // torque filter and scaling
    // ----------------------------------------------------------------
    localparam logic [5:0] SBI_TRQ_A_MUL = 6'h1A;
    localparam int SBI_FILT_SHIFT = 14;
    // 107 / 2^16 approximates 2^14 times the 100 ns clock period
    localparam logic [6:0] SBI_FILT_GAIN = 7'h6B;
    localparam int SBI_FILT_FRAC = 16;
    localparam logic [15:0] SBI_MA_PER_10V = 16'h4E20;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SBI_CLK_HZ = 10_000_000;
    localparam int SBI_NVM_WRITE_US = 50;
    localparam int SBI_NVM_CYC = SBI_NVM_WRITE_US * (SBI_CLK_HZ / 1_000_000);
    typedef enum logic [1:0] {SBI_MODE_PULSE, SBI_MODE_ANALOG,
        SBI_MODE_SERIAL, SBI_MODE_TORQUE} sbi_mode_e;
endpackage
`default_nettype wire

//--- rtl/sbi_par_if.sv
// interface carrying parameter memory accesses
`default_nettype none
interface sbi_par_if;
    logic we;
    logic [2:0] waddr;
    logic [6:0] wdata;
    logic [2:0] raddr;
    logic [6:0] rdata;
    modport ctl (output we, waddr, wdata, raddr, input rdata);
    modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

//--- rtl/sbi_par_mem.sv
// parameter memory standing in for the nonvolatile image
`default_nettype none
module sbi_par_mem
    import sbi_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic ce, // clock enable
    sbi_par_if.mem port // access port
);
    // contents outlive sys_rst like the nonvolatile image; factory values
    logic [6:0] mem_q [SBI_NPAR] = '{SBI_P_TRQ: SBI_TRQ_RST,
        SBI_P_WIN: SBI_WIN_RST, default: SBI_GAIN_RST};

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            port.rdata <= 7'h00;
        end
        else if (ce)
        begin
            if (port.we) mem_q[port.waddr] <= port.wdata;
            port.rdata <= mem_q[port.raddr];
        end
    end
endmodule // sbi_par_mem
`default_nettype wire

//--- rtl/sbi_top.sv
// brake, revolution index, serial configuration and torque scaling
// ----------------------------------------------------------------
// Summary of operation
// - window 127 makes in-position pin the brake output after power cycle.
// - powered and enabled drive holds brake output low, releasing brake.
// - disabled drive holds brake output high, engaging brake.
// - any alarm forces brake output high over enable.
// - one index pulse per revolution from 14 or 16 bit absolute position.
// - configuration port works always after power-on, in any mode.
// - point-to-point commands only in serial mode; else parameters only.
// - host is master, block only answers; several drives may share network.
// - saves and parameter writes commit configuration to nonvolatile memory.
// - gains and filter coefficient accept 1 to 127, others rejected.
// - torque command smoothed by first-order low-pass, corner 26 times coef.
// - torque reference scales linearly, +10V is 20.0A, sign sets direction.
// - in-position output high when position error within window, else low.
// ----------------------------------------------------------------
`default_nettype none
module sbi_top
    import sbi_pkg::*;
(
    input wire logic clk, // 10 MHz system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic ce, // clock enable, freezes state when low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic drive_en_pin, // enable pin, async
    input wire logic alarm_pin, // any alarm or fault, async
    input wire logic enc_16bit, // encoder resolution 16 bits when high
    input wire logic [15:0] enc_pos, // absolute encoder position
    input wire logic [15:0] pos_err_abs, // magnitude of position error
    input wire logic signed [15:0] trq_ref, // torque ref, full scale = 10V
    output logic in_position_out, // in-position or brake release pin
    output logic rev_index_pulse, // index pulse, falling edge is mark
    output logic signed [15:0] trq_cur_ma, // current command in mA
    output logic signed [15:0] trq_filt_ma, // filtered current in mA
    output logic pp_cmd_valid, // point-to-point command strobe
    output logic [31:0] pp_cmd_pos, // point-to-point target
    output logic nvm_write // one pulse per nonvolatile commit
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] en_sy_q, al_sy_q;
    logic en_q, al_q;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            en_sy_q <= 3'h0;
            al_sy_q <= 3'h7;
            en_q <= 1'b0;
            al_q <= 1'b1;
        end
        else if (ce)
        begin
            en_sy_q <= {en_sy_q[1:0], drive_en_pin};
            al_sy_q <= {al_sy_q[1:0], alarm_pin};
            if (en_sy_q[1] == en_sy_q[2]) en_q <= en_sy_q[2];
            if (al_sy_q[1] == al_sy_q[2]) al_q <= al_sy_q[2];
        end
    end

    // ----------------------------------------------------------------
    // apb decode; every access answers in its first access cycle
    // ----------------------------------------------------------------
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd_now = psel && !penable && !pwrite;
    wire hit_ctrl = paddr == SBI_CTRL_OFF;
    wire hit_stat = paddr == SBI_STAT_OFF;
    wire hit_pp = paddr == SBI_PPCMD_OFF;
    wire hit_trq = paddr == SBI_TRQ_OFF;
    wire hit_save = paddr == SBI_SAVE_OFF;

    // parameter table: one aligned word per index, indices 0 to 4 only
    wire hit_tab = paddr[7:5] == SBI_PAR_OFF[7:5] && paddr[4:2] < 3'h5
        && paddr[1:0] == 2'b00;
    wire [2:0] tab_idx = paddr[4:2];
    wire mapped = hit_ctrl || hit_stat || hit_tab || hit_pp || hit_trq
        || hit_save;

    function automatic logic par_ok(input logic [31:0] v);
        par_ok = v[31:7] == 25'h0 && v[6:0] >= SBI_PAR_MIN;
    endfunction

    sbi_mode_e mode_q;
    logic ena_sw_q, bad_q, pprej_q, brake_sel_q, sel_done_q;
    logic [15:0] saves_q;
    logic [$clog2(SBI_NVM_CYC+1)-1:0] nvm_cnt_q;
    wire nvm_busy = nvm_cnt_q != '0;
    wire par_wr = wr && hit_tab && par_ok(pwdata);
    wire par_bad = wr && hit_tab && !par_ok(pwdata);
    wire pp_ok = wr && hit_pp && mode_q == SBI_MODE_SERIAL;
    wire pp_bad = wr && hit_pp && mode_q != SBI_MODE_SERIAL;
    wire commit = par_wr || (wr && hit_save && pwdata[0]);

    sbi_par_if par ();
    sbi_par_mem u_mem (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .port(par)
    );
    logic [2:0] scan_q;
    assign par.we = ce && par_wr;
    assign par.waddr = tab_idx;
    assign par.wdata = pwdata[6:0];
    assign par.raddr = rd_now && hit_tab ? tab_idx : scan_q;

    // live copies of the window and torque coefficient, refreshed by scan
    logic [6:0] win_q, trq_q;
    logic [2:0] scan_prev_q;
    logic rd_tab_q;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            scan_q <= SBI_P_WIN;
            // memory output is not valid yet: no capture on the first edge
            scan_prev_q <= SBI_P_MAIN;
            win_q <= SBI_WIN_RST;
            trq_q <= SBI_TRQ_RST;
            rd_tab_q <= 1'b0;
        end
        else if (ce)
        begin
            rd_tab_q <= rd_now && hit_tab;
            scan_prev_q <= par.raddr;
            scan_q <= scan_q == SBI_P_WIN ? SBI_P_TRQ : SBI_P_WIN;
            if (!rd_tab_q && scan_prev_q == SBI_P_WIN) win_q <= par.rdata;
            if (!rd_tab_q && scan_prev_q == SBI_P_TRQ) trq_q <= par.rdata;
        end
    end

    // ----------------------------------------------------------------
    // control state and commits
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mode_q <= SBI_MODE_PULSE;
            ena_sw_q <= 1'b0;
            bad_q <= 1'b0;
            pprej_q <= 1'b0;
            saves_q <= 16'h0000;
            nvm_cnt_q <= '0;
            pp_cmd_valid <= 1'b0;
            pp_cmd_pos <= 32'h0000_0000;
            nvm_write <= 1'b0;
        end
        else if (ce)
        begin
            if (wr && hit_ctrl)
            begin
                ena_sw_q <= pwdata[SBI_CTRL_ENA];
                mode_q <= sbi_mode_e'(pwdata[SBI_CTRL_MODE_LO +: 2]);
            end
            // set wins over the write-one-to-clear
            if (par_bad) bad_q <= 1'b1;
            else if (wr && hit_stat && pwdata[SBI_STAT_BAD]) bad_q <= 1'b0;
            if (pp_bad) pprej_q <= 1'b1;
            else if (wr && hit_stat && pwdata[SBI_STAT_PPREJ])
                pprej_q <= 1'b0;
            pp_cmd_valid <= pp_ok;
            if (pp_ok) pp_cmd_pos <= pwdata;
            nvm_write <= commit;
            if (commit)
            begin
                saves_q <= saves_q + 16'h0001;
                nvm_cnt_q <= ($bits(nvm_cnt_q))'(SBI_NVM_CYC);
            end
            else if (nvm_busy) nvm_cnt_q <= nvm_cnt_q - 1'b1;
        end
    end

    // brake selection captured once after reset release (power cycle)
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            brake_sel_q <= 1'b0;
            sel_done_q <= 1'b0;
        end
        else if (ce && !sel_done_q && scan_prev_q == SBI_P_WIN
            && !rd_tab_q)
        begin
            brake_sel_q <= par.rdata == SBI_BRAKE_SEL;
            sel_done_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // brake and in-position pin
    // ----------------------------------------------------------------
    wire release_ok = en_q && ena_sw_q && !al_q && sel_done_q;
    wire in_pos = pos_err_abs <= {9'h000, win_q};
    always_ff @(posedge clk)
    begin
        if (sys_rst) in_position_out <= 1'b1;
        else if (ce)
        begin
            if (!sel_done_q) in_position_out <= 1'b1;
            else if (brake_sel_q)
                in_position_out <= !release_ok;
            else in_position_out <= in_pos;
        end
    end

    // ----------------------------------------------------------------
    // revolution index: low pulse at the zero crossing of position
    // ----------------------------------------------------------------
    wire [15:0] pos = enc_16bit ? enc_pos : {enc_pos[13:0], 2'b00};
    logic pos_msb_q;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            // start from the present half so reset gives no false mark
            pos_msb_q <= pos[15];
            rev_index_pulse <= 1'b1;
        end
        else if (ce)
        begin
            pos_msb_q <= pos[15];
            // one wrap per turn in either direction; falling edge marks it
            rev_index_pulse <= !(pos_msb_q != pos[15]
                && pos[14] == pos[15]);
        end
    end

    // ----------------------------------------------------------------
    // torque scaling and first-order filter
    // ----------------------------------------------------------------
    wire signed [31:0] cur_full = 32'(trq_ref) * $signed({16'h0,
        SBI_MA_PER_10V});
    wire signed [15:0] cur = 16'(cur_full >>> 15);
    wire [12:0] a_coef = 13'(trq_q * SBI_TRQ_A_MUL);
    logic signed [31:0] filt_q;
    // error kept at 48 bits so a full-scale reversal cannot wrap
    wire signed [47:0] diff = (48'($signed({cur, 16'h0000})) - 48'(filt_q))
        >>> SBI_FILT_SHIFT;
    wire signed [47:0] step = diff * $signed({35'h0, a_coef})
        * $signed({41'h0, SBI_FILT_GAIN});
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            filt_q <= 32'h0000_0000;
            trq_cur_ma <= 16'h0000;
            trq_filt_ma <= 16'h0000;
        end
        else if (ce)
        begin
            trq_cur_ma <= cur;
            filt_q <= filt_q + 32'(step >>> SBI_FILT_FRAC);
            trq_filt_ma <= filt_q[31:16];
        end
    end

    // ----------------------------------------------------------------
    // read data; table reads come from the memory's output register
    // ----------------------------------------------------------------
    logic [31:0] rd_q;
    wire [31:0] stat_w = {8'h00, saves_q, 3'h0, pprej_q, bad_q, nvm_busy,
        in_position_out, !brake_sel_q ? 1'b0 : !in_position_out};
    wire [31:0] rd_w = hit_ctrl ? {29'h0, mode_q, ena_sw_q}
        : hit_stat ? stat_w
        : hit_trq ? {16'h0, trq_filt_ma}
        : hit_pp ? pp_cmd_pos : 32'h0000_0000;
    always_ff @(posedge clk)
    begin
        if (sys_rst) rd_q <= 32'h0000_0000;
        else if (ce && rd_now) rd_q <= rd_w;
    end
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata = hit_tab ? {25'h0, par.rdata} : rd_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    brake_fault_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && brake_sel_q && al_q |=> in_position_out)
        else $error("brake released during alarm");
    brake_dis_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && brake_sel_q && !en_q |=> in_position_out)
        else $error("brake released while disabled");
    brake_rel_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && brake_sel_q && release_ok |=> !in_position_out)
        else $error("brake not released when enabled");
    brake_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
        sel_done_q && $changed(win_q) |=> $stable(brake_sel_q))
        else $error("brake selection changed before power cycle");
    in_pos_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && sel_done_q && !brake_sel_q
        |=> in_position_out == $past(in_pos))
        else $error("in-position output wrong");
    pp_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        pp_cmd_valid |-> $past(mode_q) == SBI_MODE_SERIAL)
        else $error("position command outside serial mode");
    par_range_a: assert property (@(posedge clk) disable iff (sys_rst)
        par.we |-> par.wdata >= SBI_PAR_MIN)
        else $error("out of range parameter stored");
    nvm_commit_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && commit |=> nvm_write ##1 nvm_busy)
        else $error("commit not issued");
    index_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        !rev_index_pulse |=> rev_index_pulse || !ce)
        else $error("index pulse longer than one cycle");
    apb_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
        acc |-> pready)
        else $error("port not answering");
endmodule // sbi_top
`default_nettype wire

//--- tb/sbi_host_model.sv
// apb host model acting as the configuration master of the drive
`default_nettype none
module sbi_host_model
    import sbi_pkg::*;
(
    input wire logic clk, // system clock
    output logic psel, // apb select
    output logic penable, // apb enable
    output logic pwrite, // apb direction
    output logic [7:0] paddr, // apb byte address
    output logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic rev_index_pulse, // index pulse of the drive
    output logic [15:0] index_marks // falling edges counted
);
    timeunit 1ns;
    timeprecision 1ns;
    logic index_last_q;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        index_marks = 16'h0;
        index_last_q = 1'b1;
    end
    // width and rising edge carry no meaning, only the fall is a mark
    always @(posedge clk)
    begin
        index_last_q <= rev_index_pulse;
        if (index_last_q === 1'b1 && rev_index_pulse === 1'b0)
            index_marks <= index_marks + 16'h1;
    end
    // only this task opens a transfer; parameters change only on request
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // sbi_host_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench of the brake, index and configuration block
`default_nettype none
module tb
    import sbi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, drive_en_pin = 1'b0;
    logic alarm_pin = 1'b0, enc_16bit = 1'b0, pslverr, in_position_out;
    logic psel, penable, pwrite, pready, rev_index_pulse, pp_cmd_valid;
    logic nvm_write;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, pp_cmd_pos, r;
    logic [15:0] enc_pos = 16'h3F00, pos_err_abs = 16'h0, marks;
    logic signed [15:0] trq_ref = 16'sh0, trq_cur_ma, trq_filt_ma;
    int n_errors = 0, num_checks = 0, cyc_cnt = 0, nvm_seen = 0;
    int pp_seen = 0, n0, p0;
    logic [31:0] pp_pos;
    sbi_top i_sbi_top (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .drive_en_pin(drive_en_pin),
        .alarm_pin(alarm_pin), .enc_16bit(enc_16bit), .enc_pos(enc_pos),
        .pos_err_abs(pos_err_abs), .trq_ref(trq_ref),
        .in_position_out(in_position_out),
        .rev_index_pulse(rev_index_pulse), .trq_cur_ma(trq_cur_ma),
        .trq_filt_ma(trq_filt_ma), .pp_cmd_valid(pp_cmd_valid),
        .pp_cmd_pos(pp_cmd_pos), .nvm_write(nvm_write));
    sbi_host_model i_sbi_host_model (.clk(clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rev_index_pulse(rev_index_pulse),
        .index_marks(marks));
    initial
    begin
        forever #50 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        i_sbi_host_model.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a);
        logic e;
        i_sbi_host_model.xfer(1'b0, a, 32'h0, r, e);
    endtask
    task automatic do_reset();
        sys_rst <= 1'b1;
        cyc(10);
        check({31'h0, in_position_out}, 32'h1);
        check({31'h0, rev_index_pulse}, 32'h1);
        sys_rst <= 1'b0;
        cyc(4);
    endtask
    // stepping 0x40 a cycle keeps every move far below half a turn
    task automatic sweep(input logic [15:0] s, input int n);
        for (int i = 0; i < n; i++)
        begin
            enc_pos <= s + 16'(i * 64);
            @(posedge clk);
        end
        cyc(6);
    endtask
    always @(posedge clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (nvm_write === 1'b1)
            nvm_seen <= nvm_seen + 1;
        if (pp_cmd_valid === 1'b1)
        begin
            pp_seen <= pp_seen + 1;
            pp_pos <= pp_cmd_pos;
        end
        if (cyc_cnt == 60000)
        begin
            n_errors++;
            finish_test();
        end
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_table();
        logic e;
        for (int i = 0; i < 5; i++)
        begin
            rd(8'h20 + 8'(4 * i));
            check(r, i == 4 ? 32'h0A : (i == 3 ? 32'h7F : 32'h20));
        end
        i_sbi_host_model.xfer(1'b0, 8'h40, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
    endtask
    task automatic t_params();
        rd(SBI_STAT_OFF);
        p0 = int'(r[23:8]);
        n0 = nvm_seen;
        wr(8'h20, 32'h0);
        wr(8'h20, 32'h80);
        rd(8'h20);
        check(r, 32'h20);
        rd(SBI_STAT_OFF);
        check({31'h0, r[3]}, 32'h1);
        wr(SBI_STAT_OFF, 32'h8);
        rd(SBI_STAT_OFF);
        check({31'h0, r[3]}, 32'h0);
        for (int i = 0; i < 4; i++)
            wr(8'h20 + 8'(4 * i), i[0] ? 32'h7F : 32'h01);
        for (int i = 0; i < 4; i++)
        begin
            rd(8'h20 + 8'(4 * i));
            check(r, i[0] ? 32'h7F : 32'h01);
        end
        wr(8'h20 + 8'h0C, 32'h7F);
        wr(SBI_SAVE_OFF, 32'h1);
        cyc(2);
        check(32'(nvm_seen - n0), 32'd6);
        rd(SBI_STAT_OFF);
        check({16'h0, r[23:8]}, 32'(p0 + 6));
        check({31'h0, r[2]}, 32'h1);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++)
        begin
            p0 = pp_seen;
            wr(SBI_CTRL_OFF, 32'(m * 2));
            rd(SBI_CTRL_OFF);
            check({30'h0, r[2:1]}, 32'(m));
            rd(8'h30);
            check(r, 32'h0A);
            wr(SBI_PPCMD_OFF, 32'h1234_5600 + 32'(m));
            cyc(2);
            check(32'(pp_seen - p0), m == 2 ? 32'd1 : 32'd0);
            rd(SBI_STAT_OFF);
            check({31'h0, r[4]}, m == 2 ? 32'h0 : 32'h1);
            wr(SBI_STAT_OFF, 32'h10);
        end
        check(pp_pos, 32'h1234_5602);
    endtask
    task automatic t_inpos();
        pos_err_abs <= 16'd10;
        cyc(6);
        check({31'h0, in_position_out}, 32'h1);
        pos_err_abs <= 16'd11;
        cyc(6);
        check({31'h0, in_position_out}, 32'h0);
        pos_err_abs <= 16'd0;
        wr(8'h30, 32'h7F);
        drive_en_pin <= 1'b1;
        wr(SBI_CTRL_OFF, 32'h1);
        cyc(8);
        check({31'h0, in_position_out}, 32'h1);
    endtask
    task automatic t_brake();
        do_reset();
        cyc(8);
        check({31'h0, in_position_out}, 32'h1);
        wr(SBI_CTRL_OFF, 32'h1);
        cyc(8);
        check({31'h0, in_position_out}, 32'h0);
        rd(SBI_STAT_OFF);
        check({31'h0, r[0]}, 32'h1);
        alarm_pin <= 1'b1;
        cyc(8);
        check({31'h0, in_position_out}, 32'h1);
        alarm_pin <= 1'b0;
        cyc(8);
        check({31'h0, in_position_out}, 32'h0);
        drive_en_pin <= 1'b0;
        cyc(8);
        check({31'h0, in_position_out}, 32'h1);
        drive_en_pin <= 1'b1;
        wr(SBI_CTRL_OFF, 32'h0);
        cyc(8);
        check({31'h0, in_position_out}, 32'h1);
    endtask
    task automatic t_index();
        p0 = int'(marks);
        sweep(16'h3F00, 512);
        check(32'(int'(marks) - p0), 32'd2);
        enc_16bit <= 1'b1;
        p0 = int'(marks);
        sweep(16'hBF00, 384);
        check(32'(int'(marks) - p0), 32'd1);
    endtask
    // one time constant of a = 26 * 127 is about 3028 cycles at 10 MHz
    task automatic t_torque();
        wr(SBI_CTRL_OFF, 32'h6);
        trq_ref <= 16'sd32767;
        cyc(4);
        check({16'h0, trq_cur_ma}, 32'h4E1F);
        cyc(3024);
        check({31'h0, trq_filt_ma > 16'sd11000}, 32'h1);
        check({31'h0, trq_filt_ma < 16'sd14000}, 32'h1);
        cyc(27000);
        check({31'h0, trq_filt_ma > 16'sd19800}, 32'h1);
        rd(SBI_TRQ_OFF);
        check({31'h0, $signed(r[15:0]) > 16'sd19800}, 32'h1);
        trq_ref <= -16'sd16384;
        cyc(4);
        check({16'h0, trq_cur_ma}, 32'hD8F0);
        // about two time constants from +20 A toward -10 A crosses zero
        cyc(6100);
        check({31'h0, trq_filt_ma < 16'sd0}, 32'h1);
    endtask
    initial
    begin
        do_reset();
        t_table();
        t_params();
        t_modes();
        t_inpos();
        t_brake();
        t_index();
        t_torque();
        finish_test();
    end
endmodule // tb
`default_nettype wire
